/* File: common/asd_cfg.svh */
// Purpose: Named constants for the amplifier self-diagnosis readback block
// Assumes: Included by its bare name wherever a constant is needed
// Notes: Bit positions count from bit 0 of each byte
`ifndef ASD_CFG_SVH
`define ASD_CFG_SVH

// Bus address and sub addresses
`define ASD_DEV_ADDR 7'h6C
`define ASD_SUB_FIRST 7'h01
`define ASD_SUB_SECOND 7'h02
`define ASD_SUB_FACTORY 7'h15
`define ASD_SUB_AUTOINC 7
`define ASD_BYTE_BITS 4'h8
`define ASD_BIT_ZERO 4'h0
`define ASD_IB_RESET 8'h00
`define ASD_WORD_RESET 32'h0000_0000

// First instruction byte fields
`define ASD_FIRST_TURNON_REPEAT 7
`define ASD_FIRST_DIAG_EN 6
`define ASD_FIRST_OFFSET_EN 5

// Second instruction byte fields
`define ASD_SECOND_CUR_LOW 7
`define ASD_SECOND_PIN_OFFSET 5
`define ASD_SECOND_PLAY 4
`define ASD_SECOND_CUR_EN 2

// Diagnostic byte fields
`define ASD_DB_SG 0
`define ASD_DB_SV 1
`define ASD_DB_OPEN 2
`define ASD_DB_SL 3
`define ASD_DB_PHASE 4
`define ASD_DB_CUR 5
`define ASD_DB_HI6 6
`define ASD_DB_HI7 7

// Timebase
`define ASD_CLK_KHZ 10000
`define ASD_ACQ_TIME_MS 100

`endif

/* File: common/asd_pkg.sv */
// Purpose: Types shared by the self-diagnosis readback block
// Assumes: Constants come from asd_cfg.svh
// Notes: One-hot state codes are written out
package asd_pkg;

   typedef struct packed {
      logic [3:0] sg;
      logic [3:0] sv;
      logic [3:0] op;
      logic [3:0] sl;
      logic [3:0] os;
      logic [3:0] lc;
      logic clip;
      logic therm;
   } asd_det_s;

   typedef struct packed {
      logic sg;
      logic sv;
      logic op;
      logic sl;
   } asd_flt_s;

   typedef enum logic [2:0] {
      ASD_PH_STBY = 3'b001,
      ASD_PH_TURNON = 3'b010,
      ASD_PH_PERM = 3'b100
   } asd_phase_e;

   typedef enum logic [8:0] {
      ASD_LK_IDLE = 9'b000000001,
      ASD_LK_ADDR = 9'b000000010,
      ASD_LK_ADDR_ACK = 9'b000000100,
      ASD_LK_SUB = 9'b000001000,
      ASD_LK_SUB_ACK = 9'b000010000,
      ASD_LK_WDATA = 9'b000100000,
      ASD_LK_WACK = 9'b001000000,
      ASD_LK_RDATA = 9'b010000000,
      ASD_LK_RACK = 9'b100000000
   } asd_link_e;

endpackage

/* File: src/asd_readback.sv */
// Purpose: Self-diagnosis sequencing, instruction bytes and diagnostic readback
// Assumes: link_clk oversamples scl and sda; sys_clk is the diagnosis timebase
// Notes: Link logic on link_clk, diagnosis on sys_clk, toggles and held words cross
// Notes on behaviour
// - Channel 3 byte bits 0..3: short ground, short supply, open/offset, short load.
// - Bit 4 tells phase: one permanent, zero turn-on.
// - Bit 5 shows low current only when current detection is enabled.
// - Channel 3 bit 6 echoes diagnostic cycle enable from first instruction byte.
// - Channel 3 bit 7 echoes play state from second instruction byte.
// - Channel 4 byte matches channel 3 bits 0..5; bits 6,7 read zero.
// - Short protection acts per channel; other channels keep running.
// - Turn-on phase catches shorts, output-to-output short and open speaker.
// - After enabling, turn-on results are read repeatedly without new writes.
// - First instruction byte bit 7 selects one-shot or repeat turn-on mode.
// - In one-shot mode the first read after enabling returns invalid data.
// - Permanent phase runs regardless of diagnostic enable.
// - Permanent results come back on a plain read, no write needed.
// - A removed permanent fault still shows on the next read.
// - Permanent phase follows turn-on phase automatically.
// - Offset result is live, never latched.
// - Indicator output shows clip or offset, chosen by a written bit.
// - First diagnostic byte bit 7 is the thermal warning.
// - Device answers at seven-bit address 1101100, low bit read or write.
// - A read returns the four diagnostic bytes, first to fourth.
`timescale 1ns/1ps
`include "asd_cfg.svh"

module asd_readback #(
   parameter int unsigned ACQ_CYCLES = `ASD_ACQ_TIME_MS * `ASD_CLK_KHZ
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire asd_pkg::asd_det_s det_in,
   output logic [7:0] first_instruction_byte,
   output logic [7:0] second_instruction_byte,
   output logic [3:0] prot,
   output logic ind_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Diagnostic byte builder
   function automatic logic [7:0] chan_byte(
      input asd_pkg::asd_flt_s f,
      input logic perm,
      input logic ofs,
      input logic cur,
      input logic [1:0] hi
   );
      logic [7:0] b;
      b = 8'h00;
      b[`ASD_DB_SG] = f.sg;
      b[`ASD_DB_SV] = f.sv;
      b[`ASD_DB_OPEN] = perm ? ofs : f.op;
      b[`ASD_DB_SL] = f.sl;
      b[`ASD_DB_PHASE] = perm;
      b[`ASD_DB_CUR] = cur;
      b[`ASD_DB_HI6] = hi[0];
      b[`ASD_DB_HI7] = hi[1];
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link domain reset and pin synchronisers
   logic lrst_s1;
   logic lrst_n;
   logic scl_s1;
   logic scl_s;
   logic scl_d;
   logic sda_s1;
   logic sda_s;
   logic sda_d;

   always_ff @(posedge link_clk) begin
      lrst_s1 <= rst_n;
      lrst_n <= lrst_s1;
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         scl_s1 <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s <= scl_s1;
         scl_d <= scl_s;
         sda_s1 <= sda_in;
         sda_s <= sda_s1;
         sda_d <= sda_s;
      end
   end

   logic bus_start;
   logic bus_stop;
   logic scl_rise;
   logic scl_fall;

   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;

   ////////////////////////////////////////////////////////////////////////////
   // Diagnostic word handshake into the link domain
   logic [31:0] pub_word;
   logic pub_req;
   logic req_s1;
   logic req_s2;
   logic pub_ack;
   logic [31:0] link_copy;

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         pub_ack <= 1'b0;
         link_copy <= `ASD_WORD_RESET;
      end else begin
         req_s1 <= pub_req;
         req_s2 <= req_s1;
         if (req_s2 != pub_ack) begin
            link_copy <= pub_word;
            pub_ack <= req_s2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave
   asd_pkg::asd_link_e lk_state;
   logic [3:0] bit_cnt;
   logic [7:0] rx_sh;
   logic [31:0] tx_sh;
   logic rd_mode;
   logic nack;
   logic [6:0] sub_ptr;
   logic auto_inc;
   logic [7:0] lk_first;
   logic [7:0] lk_second;
   logic wr_tog;
   logic rd_tog;

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         lk_state <= asd_pkg::ASD_LK_IDLE;
         bit_cnt <= `ASD_BIT_ZERO;
         rx_sh <= `ASD_IB_RESET;
         tx_sh <= `ASD_WORD_RESET;
         rd_mode <= 1'b0;
         nack <= 1'b0;
         sub_ptr <= `ASD_SUB_FIRST;
         auto_inc <= 1'b0;
         lk_first <= `ASD_IB_RESET;
         lk_second <= `ASD_IB_RESET;
         wr_tog <= 1'b0;
         rd_tog <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end else if (bus_start) begin
         lk_state <= asd_pkg::ASD_LK_ADDR;
         bit_cnt <= `ASD_BIT_ZERO;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         lk_state <= asd_pkg::ASD_LK_IDLE;
         sda_oe <= 1'b0;
      end else begin
         if (scl_rise) begin
            rx_sh <= {rx_sh[6:0], sda_s};
         end
         unique case (lk_state)
            asd_pkg::ASD_LK_IDLE: begin
               sda_oe <= 1'b0;
            end
            asd_pkg::ASD_LK_ADDR: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `ASD_BYTE_BITS) begin
                  if (rx_sh[7:1] == `ASD_DEV_ADDR) begin
                     rd_mode <= rx_sh[0];
                     sda_oe <= 1'b1;
                     lk_state <= asd_pkg::ASD_LK_ADDR_ACK;
                  end else begin
                     lk_state <= asd_pkg::ASD_LK_IDLE;
                  end
               end
            end
            asd_pkg::ASD_LK_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= `ASD_BIT_ZERO;
                  if (rd_mode) begin
                     tx_sh <= link_copy;
                     sda_oe <= ~link_copy[31];
                     lk_state <= asd_pkg::ASD_LK_RDATA;
                  end else begin
                     sda_oe <= 1'b0;
                     lk_state <= asd_pkg::ASD_LK_SUB;
                  end
               end
            end
            asd_pkg::ASD_LK_SUB: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `ASD_BYTE_BITS) begin
                  sub_ptr <= rx_sh[6:0];
                  auto_inc <= rx_sh[`ASD_SUB_AUTOINC];
                  sda_oe <= 1'b1;
                  lk_state <= asd_pkg::ASD_LK_SUB_ACK;
               end
            end
            asd_pkg::ASD_LK_SUB_ACK, asd_pkg::ASD_LK_WACK: begin
               if (scl_fall) begin
                  bit_cnt <= `ASD_BIT_ZERO;
                  sda_oe <= 1'b0;
                  lk_state <= asd_pkg::ASD_LK_WDATA;
               end
            end
            asd_pkg::ASD_LK_WDATA: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `ASD_BYTE_BITS) begin
                  if (sub_ptr == `ASD_SUB_FIRST) begin
                     lk_first <= rx_sh;
                  end else if (sub_ptr == `ASD_SUB_SECOND) begin
                     lk_second <= rx_sh;
                  end
                  if (auto_inc) begin
                     sub_ptr <= sub_ptr + 7'h01;
                  end
                  wr_tog <= ~wr_tog;
                  sda_oe <= 1'b1;
                  lk_state <= asd_pkg::ASD_LK_WACK;
               end
            end
            asd_pkg::ASD_LK_RDATA: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == `ASD_BYTE_BITS) begin
                     sda_oe <= 1'b0;
                     lk_state <= asd_pkg::ASD_LK_RACK;
                  end else begin
                     tx_sh <= {tx_sh[30:0], 1'b0};
                     sda_oe <= ~tx_sh[30];
                  end
               end
            end
            asd_pkg::ASD_LK_RACK: begin
               if (scl_rise) begin
                  nack <= sda_s;
               end else if (scl_fall) begin
                  bit_cnt <= `ASD_BIT_ZERO;
                  if (nack) begin
                     rd_tog <= ~rd_tog;
                     lk_state <= asd_pkg::ASD_LK_IDLE;
                  end else begin
                     tx_sh <= {tx_sh[30:0], 1'b0};
                     sda_oe <= ~tx_sh[30];
                     lk_state <= asd_pkg::ASD_LK_RDATA;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event and detector crossings into the system domain
   logic [2:0] wr_sync;
   logic [2:0] rd_sync;
   logic [1:0] ack_sync;
   asd_pkg::asd_det_s det_s1;
   asd_pkg::asd_det_s det;
   logic wr_evt;
   logic rd_evt;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_sync <= 3'h0;
         rd_sync <= 3'h0;
         ack_sync <= 2'h0;
         det_s1 <= '0;
         det <= '0;
      end else begin
         wr_sync <= {wr_sync[1:0], wr_tog};
         rd_sync <= {rd_sync[1:0], rd_tog};
         ack_sync <= {ack_sync[0], pub_ack};
         det_s1 <= det_in;
         det <= det_s1;
      end
   end

   assign wr_evt = wr_sync[2] ^ wr_sync[1];
   assign rd_evt = rd_sync[2] ^ rd_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // Instruction bytes
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         first_instruction_byte <= `ASD_IB_RESET;
         second_instruction_byte <= `ASD_IB_RESET;
      end else if (wr_evt) begin
         first_instruction_byte <= lk_first;
         second_instruction_byte <= lk_second;
      end
   end

   logic play;
   logic diag_en;
   logic repeat_mode;

   assign play = second_instruction_byte[`ASD_SECOND_PLAY];
   assign diag_en = first_instruction_byte[`ASD_FIRST_DIAG_EN];
   assign repeat_mode = first_instruction_byte[`ASD_FIRST_TURNON_REPEAT];

   ////////////////////////////////////////////////////////////////////////////
   // Diagnosis phase sequencing
   asd_pkg::asd_phase_e phase;
   logic [31:0] acq_cnt;
   logic diag_term;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phase <= asd_pkg::ASD_PH_STBY;
         acq_cnt <= `ASD_WORD_RESET;
         diag_term <= 1'b0;
      end else if (!play) begin
         phase <= asd_pkg::ASD_PH_STBY;
         diag_term <= 1'b0;
      end else begin
         unique case (phase)
            asd_pkg::ASD_PH_STBY: begin
               acq_cnt <= `ASD_WORD_RESET;
               phase <= diag_en ? asd_pkg::ASD_PH_TURNON : asd_pkg::ASD_PH_PERM;
            end
            asd_pkg::ASD_PH_TURNON: begin
               if (acq_cnt == ACQ_CYCLES - 1) begin
                  diag_term <= 1'b1;
                  phase <= asd_pkg::ASD_PH_PERM;
               end else begin
                  acq_cnt <= acq_cnt + 32'h1;
               end
            end
            asd_pkg::ASD_PH_PERM: begin
               if (rd_evt && diag_en && repeat_mode) begin
                  acq_cnt <= `ASD_WORD_RESET;
                  diag_term <= 1'b0;
                  phase <= asd_pkg::ASD_PH_TURNON;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault capture per channel
   asd_pkg::asd_flt_s [3:0] live;
   asd_pkg::asd_flt_s [3:0] lat;
   logic read_valid;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         live[i].sg = det.sg[i];
         live[i].sv = det.sv[i];
         live[i].op = det.op[i];
         live[i].sl = det.sl[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lat <= '0;
      end else if (phase == asd_pkg::ASD_PH_STBY) begin
         lat <= '0;
      end else if (phase == asd_pkg::ASD_PH_TURNON) begin
         lat <= lat | live;
      end else if (rd_evt) begin
         lat <= live;
      end else begin
         lat <= lat | live;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         read_valid <= 1'b0;
      end else if (wr_evt && lk_first[`ASD_FIRST_DIAG_EN]) begin
         read_valid <= 1'b0;
      end else if (rd_evt) begin
         read_valid <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Diagnostic word assembly and publication
   logic perm;
   logic ofs_en;
   logic cur_en;
   logic mask;
   logic [7:0] db [4];

   assign perm = (phase == asd_pkg::ASD_PH_PERM);
   assign ofs_en = first_instruction_byte[`ASD_FIRST_OFFSET_EN];
   assign cur_en = second_instruction_byte[`ASD_SECOND_CUR_EN];
   assign mask = ~read_valid & ~repeat_mode & diag_en;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         db[i] = chan_byte(mask ? '0 : lat[i], perm,
            ofs_en & det.os[i],
            cur_en & det.lc[i],
            2'b00);
      end
      db[0][`ASD_DB_HI6] = diag_term;
      db[0][`ASD_DB_HI7] = det.therm;
      db[1][`ASD_DB_HI6] = cur_en;
      db[1][`ASD_DB_HI7] = ofs_en;
      db[2][`ASD_DB_HI6] = diag_en;
      db[2][`ASD_DB_HI7] = play;
      db[3][`ASD_DB_HI6] = 1'b0;
      db[3][`ASD_DB_HI7] = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pub_word <= `ASD_WORD_RESET;
         pub_req <= 1'b0;
      end else if (ack_sync[1] == pub_req) begin
         pub_word <= {db[0], db[1], db[2], db[3]};
         pub_req <= ~pub_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protection and indicator outputs
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prot <= 4'h0;
         ind_out <= 1'b0;
      end else begin
         prot <= det.sg | det.sv | det.sl;
         if (second_instruction_byte[`ASD_SECOND_PIN_OFFSET]) begin
            ind_out <= |det.os;
         end else begin
            ind_out <= det.clip;
         end
      end
   end

endmodule

/* File: testbench/asd_readback_props.sv */
// Purpose: Port assertions for the diagnosis readback block
// Assumes: Bound to asd_readback from tb_top
// Notes: Settle counters cover synchroniser latency
`timescale 1ns/1ps
module asd_readback_props #(
   parameter int unsigned ACQ_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire asd_pkg::asd_det_s det_in,
   input wire logic [7:0] first_instruction_byte,
   input wire logic [7:0] second_instruction_byte,
   input wire logic [3:0] prot,
   input wire logic ind_out
);
   logic [3:0] settle;
   logic [4:0] quiet;
   logic [5:0] hi_cnt;
   asd_pkg::asd_det_s det_q;
   logic [7:0] second_q;
   logic scl_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles with detectors and second byte unchanged
   always_ff @(posedge sys_clk) begin
      det_q <= det_in;
      second_q <= second_instruction_byte;
      if (!rst_n || det_in != det_q || second_instruction_byte != second_q) settle <= 4'h0;
      else if (settle != 4'hF) settle <= settle + 4'h1;
   end
   // Cycles since the serial clock last moved
   always_ff @(posedge sys_clk) begin
      scl_q <= scl_in;
      if (!rst_n || scl_in != scl_q) quiet <= 5'h00;
      else if (quiet != 5'h1F) quiet <= quiet + 5'h01;
   end
   // Link cycles with the serial clock high
   always_ff @(posedge link_clk) begin
      if (!rst_n || !scl_in) hi_cnt <= 6'h00;
      else if (hi_cnt != 6'h3F) hi_cnt <= hi_cnt + 6'h01;
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_settled;
      settle >= 4'h6 && det_in == det_q && second_instruction_byte == second_q;
   endsequence
   property p_prot;
      @(posedge sys_clk) disable iff (!rst_n)
         s_settled |-> prot == (det_in.sg | det_in.sv | det_in.sl);
   endproperty
   a_prot: assert property (p_prot) else $error("prot does not follow shorts");
   property p_ind;
      @(posedge sys_clk) disable iff (!rst_n)
         s_settled |-> ind_out == (second_instruction_byte[5] ? |det_in.os : det_in.clip);
   endproperty
   a_ind: assert property (p_ind) else $error("ind_out wrong source");
   property p_reset_clear;
      @(posedge sys_clk) !rst_n |=> first_instruction_byte == 8'h00 &&
         second_instruction_byte == 8'h00 && prot == 4'h0 && !ind_out;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
   property p_ib_quiet;
      @(posedge sys_clk) disable iff (!rst_n) quiet >= 5'h0C |->
         $stable(first_instruction_byte) && $stable(second_instruction_byte);
   endproperty
   a_ib_quiet: assert property (p_ib_quiet) else $error("byte changed on idle bus");
   property p_sda_out;
      @(posedge link_clk) disable iff (!rst_n) sda_oe |-> !sda_out;
   endproperty
   a_sda_out: assert property (p_sda_out) else $error("sda driven high");
   property p_oe_rise;
      @(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) |-> !scl_in;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("sda taken with scl high");
   property p_oe_fall;
      @(posedge link_clk) disable iff (!rst_n) $fell(sda_oe) |-> !scl_in;
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("sda freed with scl high");
   property p_idle_release;
      @(posedge link_clk) disable iff (!rst_n) hi_cnt >= 6'h28 |-> !sda_oe;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("sda held on idle");
endmodule

/* File: testbench/asd_host.sv */
// Purpose: Serial bus controller model standing for the host
// Assumes: Open-drain line level resolved in tb_top
// Notes: Clock stands high between frames; 200 ns bit time
`timescale 1ns/1ps
module asd_host (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   localparam int H = 100;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic start_cond();
      sda_low = 1'b1;
      #(H);
      scl = 1'b0;
   endtask
   task automatic stop_cond();
      #(H / 4);
      sda_low = 1'b1;
      #(3 * H / 4);
      scl = 1'b1;
      #(H);
      sda_low = 1'b0;
      #(3 * H);
   endtask
   task automatic put_bit(input logic b);
      #(H / 4);
      sda_low = ~b;
      #(3 * H / 4);
      scl = 1'b1;
      #(H);
      scl = 1'b0;
   endtask
   task automatic get_bit(output logic b);
      #(H / 4);
      sda_low = 1'b0;
      #(3 * H / 4);
      scl = 1'b1;
      #(H / 2);
      b = sda;
      #(H / 2);
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(ack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(last);
   endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the diagnosis readback block
// Assumes: asd_host drives the serial bus with a pull-up on sda
// Notes: Short turn-on window for simulation
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned ACQ = 300;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl_in, sda_in, sda_out, sda_oe, ind_out, host_low, a;
   logic [7:0] first_instruction_byte, second_instruction_byte;
   logic [3:0] prot;
   asd_pkg::asd_det_s det_in = '0;
   logic [31:0] w;
   int bad_count = 0;
   int tests_run = 0;
   assign sda_in = ~(host_low | sda_oe);
   asd_readback #(.ACQ_CYCLES(ACQ)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .det_in(det_in), .first_instruction_byte(first_instruction_byte),
      .second_instruction_byte(second_instruction_byte), .prot(prot), .ind_out(ind_out));
   asd_host host (.scl(scl_in), .sda_low(host_low), .sda(sda_in));
   always #50 sys_clk = ~sys_clk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1,
                     input int n);
      logic k;
      host.start_cond();
      host.wbyte(8'hD8, k);
      check("wr_addr_ack", k, 1'b0);
      host.wbyte(sub, k);
      host.wbyte(d0, k);
      if (n > 1) host.wbyte(d1, k);
      host.stop_cond();
      cyc(10);
   endtask
   task automatic rd(output logic [31:0] d);
      logic k;
      host.start_cond();
      host.wbyte(8'hD9, k);
      check("rd_addr_ack", k, 1'b0);
      for (int i = 0; i < 4; i++) host.rbyte(i == 3, d[31 - 8 * i -: 8]);
      host.stop_cond();
   endtask
   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge sys_clk);
      bad_count++;
      $display("ERROR watchdog expected end seen hang");
      finish_test();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(4);
      check("first_rst", first_instruction_byte, 8'h00);
      check("second_rst", second_instruction_byte, 8'h00);
      rd(w);
      check("word_rst", w, 32'h0000_0000);
      done("reset");
      host.start_cond();
      host.wbyte(8'hDA, a);
      host.stop_cond();
      check("foreign_ack", a, 1'b1);
      wr(8'h15, 8'hFF, 8'h00, 1);
      check("first_factory", first_instruction_byte, 8'h00);
      done("refuse");
      @(posedge sys_clk);
      det_in.sg[2] <= 1'b1;
      det_in.sv[3] <= 1'b1;
      wr(8'h81, 8'h60, 8'h14, 2);
      check("first_wr", first_instruction_byte, 8'h60);
      check("second_wr", second_instruction_byte, 8'h14);
      rd(w);
      check("db3_invalid", w[15:8], 8'hC0);
      check("db4_invalid", w[7:0], 8'h00);
      rd(w);
      check("db3_turnon", w[15:8], 8'hC1);
      check("db4_turnon", w[7:0], 8'h02);
      @(posedge sys_clk);
      det_in.lc[3] <= 1'b1;
      cyc(ACQ);
      rd(w);
      check("diag1_term", w[30], 1'b1);
      check("db3_perm", w[15:8], 8'hD1);
      check("db4_perm", w[7:0], 8'h32);
      done("turn_on");
      @(posedge sys_clk);
      det_in.sg <= 4'h0;
      det_in.sv <= 4'h0;
      cyc(10);
      rd(w);
      check("db3_removed1", w[15:8], 8'hD1);
      rd(w);
      check("db3_removed2", w[15:8], 8'hD0);
      @(posedge sys_clk);
      det_in.os[2] <= 1'b1;
      det_in.therm <= 1'b1;
      cyc(10);
      rd(w);
      check("db3_offset", w[15:8], 8'hD4);
      check("diag1_therm", w[31], 1'b1);
      @(posedge sys_clk);
      det_in.os[2] <= 1'b0;
      det_in.therm <= 1'b0;
      cyc(10);
      rd(w);
      check("db3_offset0", w[15:8], 8'hD0);
      @(posedge sys_clk);
      det_in.clip <= 1'b1;
      det_in.sg[0] <= 1'b1;
      cyc(10);
      check("prot", prot, 4'h1);
      check("ind_clip", ind_out, 1'b1);
      wr(8'h02, 8'h34, 8'h00, 1);
      check("ind_offset", ind_out, 1'b0);
      @(posedge sys_clk);
      det_in <= '0;
      done("permanent");
      wr(8'h02, 8'h00, 8'h00, 1);
      wr(8'h81, 8'h00, 8'h14, 2);
      rd(w);
      check("db3_nodiag", w[15:8], 8'h90);
      wr(8'h02, 8'h00, 8'h00, 1);
      wr(8'h81, 8'hC0, 8'h14, 2);
      cyc(ACQ + 100);
      rd(w);
      check("db3_repeat1", w[15:8], 8'hD0);
      rd(w);
      check("db3_repeat2", w[15:8], 8'hC0);
      done("modes");
      finish_test();
   end
endmodule
bind asd_readback asd_readback_props #(.ACQ_CYCLES(ACQ_CYCLES)) u_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .det_in(det_in),
   .first_instruction_byte(first_instruction_byte),
   .second_instruction_byte(second_instruction_byte), .prot(prot), .ind_out(ind_out));
